// >>> logic/cmd_scaler.sv
// Purpose: Scales a filter result onto the signed analog command code.
// Assumes: Code +7FFF is +10 V, 8001 is -10 V.
// Notes:   Purely combinational; clamps instead of wrapping.
`timescale 1ns/10ps
`default_nettype none
module cmd_scaler #(
  parameter int unsigned IN_W  = servo_filter_pkg::SUM_W,
  parameter int unsigned SHIFT = 0
) (
  input  wire logic signed [IN_W-1:0] value,
  output logic signed [15:0]          code,
  output logic                        sat
);
  import servo_filter_pkg::*;

  logic signed [IN_W-1:0] shifted;

  always_comb begin
    shifted = value >>> SHIFT;
    sat     = 1'b0;
    code    = shifted[15:0];
    if (shifted > IN_W'(DAC_POS_FULL)) begin
      code = DAC_POS_FULL;
      sat  = 1'b1;
    end else if (shifted < IN_W'(DAC_NEG_FULL)) begin
      code = DAC_NEG_FULL;
      sat  = 1'b1;
    end
  end

endmodule : cmd_scaler
`default_nettype wire

// >>> logic/sample_tick.sv
// Purpose: Divides pclk into a one-cycle sample strobe.
// Assumes: DIV of at least 2.
// Notes:   Strobe every DIV cycles, first one DIV cycles after reset.
`timescale 1ns/10ps
`default_nettype none
module sample_tick #(
  parameter int unsigned DIV = servo_filter_pkg::SAMPLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  import servo_filter_pkg::*;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TICK_CNT_W'(DIV - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : sample_tick
`default_nettype wire

// >>> logic/servo_filter_pkg.sv
// Purpose: Shared constants, types and register map of the servo loop filter.
// Assumes: 100 MHz pclk; APB with 32-bit data, one aligned word per register.
// Notes:   Printed register numbers are indices; byte address is four times the index.
package servo_filter_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SAMPLE_HZ     = 2048;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned TICK_CNT_W    = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses
  localparam logic [15:0] IDX_VEL_FF    = 16'h38A5;
  localparam logic [15:0] IDX_ACCEL_FF  = 16'h39D1;
  localparam logic [15:0] IDX_DECEL     = 16'h3A9E;
  localparam logic [15:0] IDX_MODE_SEL  = 16'h4269;
  localparam logic [31:0] ADDR_VEL_FF   = {14'h0000, IDX_VEL_FF, 2'b00};
  localparam logic [31:0] ADDR_ACCEL_FF = {14'h0000, IDX_ACCEL_FF, 2'b00};
  localparam logic [31:0] ADDR_DECEL    = {14'h0000, IDX_DECEL, 2'b00};
  localparam logic [31:0] ADDR_MODE_SEL = {14'h0000, IDX_MODE_SEL, 2'b00};
  localparam logic [31:0] ADDR_PROF_P   = 32'h0001_0A00;
  localparam logic [31:0] ADDR_PROF_I   = 32'h0001_0A04;
  localparam logic [31:0] ADDR_PROF_D   = 32'h0001_0A08;
  localparam logic [31:0] ADDR_PROF_ACC = 32'h0001_0A0C;
  localparam logic [31:0] ADDR_PROF_CMD = 32'h0001_0A10;
  localparam logic [31:0] ADDR_STATUS   = 32'h0001_0A14;
  localparam logic [31:0] ADDR_ACC_RATE = 32'h0001_0A18;

  // Command word bits and status field positions
  localparam int unsigned CMD_PROFILE_BIT = 0;
  localparam int unsigned CMD_ZERO_BIT    = 1;
  localparam int unsigned ST_PROFILED_BIT = 4;
  localparam int unsigned ST_SAT_BIT      = 5;
  localparam int unsigned ST_CODE_LSB     = 16;

  // Filter selection values
  localparam logic [31:0] FSEL_DIR_NEG = 32'h0000_0001;
  localparam logic [31:0] FSEL_DIR_POS = 32'h0000_0002;
  localparam logic [31:0] FSEL_FF      = 32'h0000_0005;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic widths and output span (code 7FFF is +10 V)
  localparam int unsigned ACC_W   = 48;
  localparam int unsigned SUM_W   = 72;
  localparam int unsigned VOLT_FS = 10;
  localparam logic signed [15:0] DAC_POS_FULL = 16'sh7FFF;
  localparam logic signed [15:0] DAC_NEG_FULL = 16'sh8001;

  typedef enum logic [3:0] {
    MODE_PID     = 4'b0001,
    MODE_FF      = 4'b0010,
    MODE_DIR_NEG = 4'b0100,
    MODE_DIR_POS = 4'b1000
  } mode_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic signed [31:0] actual;
  } pos_in_t;

  typedef struct packed {
    logic signed [15:0] code;
    logic               sat;
    logic               active;
  } cmd_out_t;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic                  tick;
  } tick_state_t;

  typedef struct packed {
    logic [31:0]             vel_ff;
    logic [31:0]             accel_ff;
    logic [31:0]             decel;
    logic [31:0]             mode_sel;
    logic [31:0]             accel_prof;
    logic [31:0]             accel_rate;
    logic [7:0]              kp;
    logic [7:0]              ki;
    logic [7:0]              kd;
    mode_t                   mode;
    logic                    profiled;
    logic signed [31:0]      prev_err;
    logic signed [ACC_W-1:0] accum;
    logic signed [31:0]      last_target;
    logic signed [31:0]      last_vel;
    logic signed [15:0]      cmd;
    logic                    sat;
    logic [31:0]             rdata;
  } state_t;

  localparam state_t STATE_RST = '{mode: MODE_PID, default: '0};

endpackage : servo_filter_pkg

// >>> logic/servo_loop_filter.sv
// Purpose: Per-axis servo loop filter with APB registers and signed command out.
// Assumes: Position inputs come from logic on pclk; pready answers in the access cycle.
// Notes:   Filter selection latches at each profile command.
// Contract
// - PID law unless filter register selects otherwise
// - Error is intended minus actual position
// - Recompute command 2048 times per second
// - PID: P times error, D delta, I sum
// - Then accumulate error, keep it as previous
// - Scale result to bipolar plus/minus ten volts
// - Value 5 selects proportional feedforward mode
// - Feedforward: P error, accel and velocity terms
// - Feedforward mode ignores integral and derivative gains
// - Feedforward gains come from two dedicated registers
// - Direct mode maps 0..32767 to 0..10 V
// - Value 1 negative, 2 positive direct mode
// - Direct mode only after completed profile command
// - Profile acceleration loads acceleration and deceleration
// - Deceleration register overrides deceleration rate
// - New acceleration overwrites previous deceleration rate
`timescale 1ns/10ps
`default_nettype none
module servo_loop_filter #(
  parameter int unsigned SAMPLE_DIV = servo_filter_pkg::SAMPLE_CYCLES,
  parameter int unsigned OUT_SHIFT  = 0
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire servo_filter_pkg::pos_in_t  pos_in,
  output servo_filter_pkg::cmd_out_t      cmd_out
);
  import servo_filter_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  state_t                  s_q;
  state_t                  s_d;
  logic                    tick;
  logic                    access;
  logic                    wr_en;
  logic                    hit;
  logic                    profile_cmd;
  logic                    zero_cmd;
  logic [31:0]             rd_val;
  logic signed [31:0]      err;
  logic signed [SUM_W-1:0] err_x;
  logic signed [SUM_W-1:0] kp_x;
  logic signed [SUM_W-1:0] ki_x;
  logic signed [SUM_W-1:0] kd_x;
  logic signed [SUM_W-1:0] vel_x;
  logic signed [SUM_W-1:0] dvel_x;
  logic signed [SUM_W-1:0] pid_sum;
  logic signed [SUM_W-1:0] ff_sum;
  logic signed [SUM_W-1:0] filt_sum;
  logic signed [15:0]      scaled;
  logic                    scaled_sat;
  logic [15:0]             dir_mag;
  logic signed [15:0]      dir_code;
  mode_t                   sel_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample strobe and output scaling
  sample_tick #(
    .DIV (SAMPLE_DIV)
  ) u_tick (
    .clk   (pclk),
    .rst_n (presetn),
    .tick  (tick)
  );

  cmd_scaler #(
    .IN_W  (SUM_W),
    .SHIFT (OUT_SHIFT)
  ) u_scale (
    .value (filt_sum),
    .code  (scaled),
    .sat   (scaled_sat)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign access      = psel && penable;
  assign wr_en       = access && pwrite;
  assign profile_cmd = wr_en && (paddr == ADDR_PROF_CMD) && pwdata[CMD_PROFILE_BIT];
  assign zero_cmd    = wr_en && (paddr == ADDR_PROF_CMD) && pwdata[CMD_ZERO_BIT];
  assign pready      = access;
  assign pslverr     = access && !hit;
  assign prdata      = s_q.rdata;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_VEL_FF:   rd_val = s_q.vel_ff;
      ADDR_ACCEL_FF: rd_val = s_q.accel_ff;
      ADDR_DECEL:    rd_val = s_q.decel;
      ADDR_MODE_SEL: rd_val = s_q.mode_sel;
      ADDR_PROF_P:   rd_val = {24'h000000, s_q.kp};
      ADDR_PROF_I:   rd_val = {24'h000000, s_q.ki};
      ADDR_PROF_D:   rd_val = {24'h000000, s_q.kd};
      ADDR_PROF_ACC: rd_val = s_q.accel_prof;
      ADDR_PROF_CMD: rd_val = 32'h0000_0000;
      ADDR_STATUS: begin
        rd_val[3:0]                      = s_q.mode;
        rd_val[ST_PROFILED_BIT]          = s_q.profiled;
        rd_val[ST_SAT_BIT]               = s_q.sat;
        rd_val[ST_CODE_LSB+15:ST_CODE_LSB] = s_q.cmd;
      end
      ADDR_ACC_RATE: rd_val = s_q.accel_rate;
      default:       hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filter arithmetic
  always_comb begin
    err      = pos_in.target - pos_in.actual;
    err_x    = SUM_W'(err);
    kp_x     = SUM_W'($signed({1'b0, s_q.kp}));
    ki_x     = SUM_W'($signed({1'b0, s_q.ki}));
    kd_x     = SUM_W'($signed({1'b0, s_q.kd}));
    vel_x    = SUM_W'(pos_in.target) - SUM_W'(s_q.last_target);
    dvel_x   = vel_x - SUM_W'(s_q.last_vel);
    pid_sum  = err_x * kp_x
             + (err_x - SUM_W'(s_q.prev_err)) * kd_x
             + SUM_W'(s_q.accum) * ki_x;
    ff_sum   = err_x * kp_x
             + dvel_x * SUM_W'($signed(s_q.accel_ff))
             + vel_x * SUM_W'($signed(s_q.vel_ff));
    filt_sum = (s_q.mode == MODE_FF) ? ff_sum : pid_sum;
  end

  // Open-loop magnitude: negative values read as zero, large ones clamp
  always_comb begin
    if (s_q.vel_ff[31]) begin
      dir_mag = 16'h0000;
    end else if (|s_q.vel_ff[30:15]) begin
      dir_mag = DAC_POS_FULL;
    end else begin
      dir_mag = {1'b0, s_q.vel_ff[14:0]};
    end
    dir_code = (s_q.mode == MODE_DIR_NEG) ? $signed(16'h0000 - dir_mag)
                                          : $signed(dir_mag);
  end

  // Filter selection is sampled only when a profile command is taken
  always_comb begin
    case (s_q.mode_sel)
      FSEL_FF:      sel_mode = MODE_FF;
      FSEL_DIR_NEG: sel_mode = MODE_DIR_NEG;
      FSEL_DIR_POS: sel_mode = MODE_DIR_POS;
      default:      sel_mode = MODE_PID;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    if (psel && !penable) begin
      s_d.rdata = rd_val;
    end
    if (wr_en) begin
      case (paddr)
        ADDR_VEL_FF:   s_d.vel_ff = pwdata;
        ADDR_ACCEL_FF: s_d.accel_ff = pwdata;
        ADDR_DECEL:    s_d.decel = pwdata;
        ADDR_MODE_SEL: s_d.mode_sel = pwdata;
        ADDR_PROF_P:   s_d.kp = pwdata[7:0];
        ADDR_PROF_I:   s_d.ki = pwdata[7:0];
        ADDR_PROF_D:   s_d.kd = pwdata[7:0];
        ADDR_PROF_ACC: s_d.accel_prof = pwdata;
        default: begin
        end
      endcase
    end
    if (tick) begin
      s_d.last_target = pos_in.target;
      s_d.last_vel    = vel_x[31:0];
      if (!s_q.profiled) begin
        s_d.cmd = 16'sh0000;
        s_d.sat = 1'b0;
      end else begin
        case (s_q.mode)
          MODE_PID: begin
            s_d.cmd      = scaled;
            s_d.sat      = scaled_sat;
            s_d.accum    = s_q.accum + ACC_W'(err);
            s_d.prev_err = err;
          end
          MODE_FF: begin
            s_d.cmd = scaled;
            s_d.sat = scaled_sat;
          end
          MODE_DIR_NEG, MODE_DIR_POS: begin
            s_d.cmd = dir_code;
            s_d.sat = 1'b0;
          end
          default: begin
            s_d.cmd = 16'sh0000;
            s_d.sat = 1'b0;
          end
        endcase
      end
    end
    if (profile_cmd) begin
      s_d.accel_rate = s_q.accel_prof;
      s_d.decel      = s_q.accel_prof;
      s_d.mode       = sel_mode;
      s_d.profiled   = 1'b1;
    end
    if (profile_cmd || zero_cmd) begin
      s_d.accum    = '0;
      s_d.prev_err = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_out.code   = s_q.cmd;
  assign cmd_out.sat    = s_q.sat;
  assign cmd_out.active = s_q.profiled;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [TICK_CNT_W-1:0] tick_gap_q;
  logic                  tick_seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap_q  <= '0;
      tick_seen_q <= 1'b0;
    end else if (tick) begin
      tick_gap_q  <= '0;
      tick_seen_q <= 1'b1;
    end else begin
      tick_gap_q <= tick_gap_q + 1'b1;
    end
  end

  tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && tick_seen_q) |-> (tick_gap_q == TICK_CNT_W'(SAMPLE_DIV - 1)))
    else $error("sample strobe spacing wrong");

  pid_accum_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_PID && !profile_cmd && !zero_cmd)
    |=> (s_q.accum == $past(s_q.accum) + ACC_W'($past(err)))
        && (s_q.prev_err == $past(err)))
    else $error("error sum or previous error not updated");

  clear_on_profile_a: assert property (@(posedge pclk) disable iff (!presetn)
    (profile_cmd || zero_cmd) |=> (s_q.accum == '0) && (s_q.prev_err == '0))
    else $error("sum not cleared by profile or zero");

  decel_follows_accel_a: assert property (@(posedge pclk) disable iff (!presetn)
    profile_cmd |=> (s_q.decel == s_q.accel_rate) && (s_q.accel_rate == $past(s_q.accel_prof)))
    else $error("profile did not load both rates");

  decel_override_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_DECEL) |=> (s_q.decel == $past(pwdata))
        && $stable(s_q.accel_rate))
    else $error("deceleration write not applied");

  mode_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    profile_cmd |=> (s_q.mode == (($past(s_q.mode_sel) == FSEL_FF) ? MODE_FF :
                     ($past(s_q.mode_sel) == FSEL_DIR_NEG) ? MODE_DIR_NEG :
                     ($past(s_q.mode_sel) == FSEL_DIR_POS) ? MODE_DIR_POS : MODE_PID)))
    else $error("filter mode not taken from selection");

  direct_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.profiled |-> (s_q.cmd == 16'sh0000) && (s_q.mode == MODE_PID))
    else $error("command driven before profile");

  sat_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_PID && scaled_sat)
    |=> (s_q.cmd == DAC_POS_FULL || s_q.cmd == DAC_NEG_FULL) && s_q.sat)
    else $error("saturated command not at full scale");

  direct_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_DIR_NEG && !s_q.vel_ff[31])
    |=> (s_q.cmd <= 16'sh0000))
    else $error("negative direct command has wrong sign");

  direct_pos_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_DIR_POS)
    |=> (s_q.cmd >= 16'sh0000))
    else $error("positive direct command has wrong sign");

  direct_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_DIR_POS && s_q.vel_ff[31:15] == '0)
    |=> (s_q.cmd == $signed({1'b0, $past(s_q.vel_ff[14:0])})))
    else $error("direct command not equal to velocity value");

  cmd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tick
    |=> $stable(s_q.cmd) && $stable(s_q.sat))
    else $error("command changed between sample strobes");

  sum_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !profile_cmd && !zero_cmd)
    |=> $stable(s_q.accum) && $stable(s_q.prev_err))
    else $error("error sum moved without a sample");

  ff_sum_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.mode == MODE_FF && !profile_cmd && !zero_cmd)
    |=> $stable(s_q.accum) && $stable(s_q.prev_err))
    else $error("error sum updated in feedforward mode");

  sat_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && s_q.profiled && s_q.mode == MODE_PID && !scaled_sat)
    |=> !s_q.sat)
    else $error("saturation flag set on an in-range result");

  mode_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    !profile_cmd
    |=> $stable(s_q.mode) && $stable(s_q.profiled))
    else $error("filter mode changed without a profile command");

  rate_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    !profile_cmd
    |=> $stable(s_q.accel_rate))
    else $error("acceleration rate changed without a profile command");

  unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !hit)
    |=> $stable(s_q.vel_ff) && $stable(s_q.accel_ff) && $stable(s_q.decel)
        && $stable(s_q.mode_sel) && $stable(s_q.accel_prof))
    else $error("write to unmapped address changed a register");

endmodule : servo_loop_filter
`default_nettype wire

// >>> testbench/drive_model.sv
// Purpose: Servo drive and encoder stand-in facing the loop filter.
// Assumes: Bench moves the commanded position and picks the following lag.
// Notes:   Encoder reads commanded position minus lag, so the error is known.
`timescale 1ns/10ps
`default_nettype none
module drive_model (
  input  wire logic signed [31:0]         target,
  input  wire logic signed [31:0]         lag,
  output servo_filter_pkg::pos_in_t       pos
);
  import servo_filter_pkg::*;
  // Combinational so that position and encoder never disagree across a sample
  assign pos.target = target;
  assign pos.actual = target - lag;
endmodule : drive_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the servo loop filter.
// Assumes: Sample divider shortened to 16 pclk to keep the run short.
// Notes:   Command codes are polled with a bounded wait per expected value.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import servo_filter_pkg::*;
  localparam int unsigned DIV = 16;
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [31:0]        paddr   = '0;
  logic [31:0]        pwdata  = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic signed [31:0] target  = '0;
  logic signed [31:0] lag     = '0;
  pos_in_t            pos_in;
  cmd_out_t           cmd_out;
  int                 n_fail  = 0;
  int                 checked = 0;
  logic [31:0]        rd;
  logic               err;

  always #5 pclk = ~pclk;

  servo_loop_filter #(.SAMPLE_DIV(DIV), .OUT_SHIFT(0)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_in(pos_in), .cmd_out(cmd_out)
  );

  drive_model drv (.target(target), .lag(lag), .pos(pos_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_code(input logic [15:0] e);
    int n;
    n = 0;
    while (cmd_out.code !== e && n < 4 * DIV) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("cmd_code", {16'h0000, e}, {16'h0000, cmd_out.code});
    if (cmd_out.code !== e) begin
      end_sim();
    end
  endtask : wait_code

  task automatic set_pos(input logic signed [31:0] t, input logic signed [31:0] l);
    @(posedge pclk);
    target <= t;
    lag    <= l;
  endtask : set_pos

  task automatic prof(input logic [31:0] p, i, d, acc);
    apb(1'b1, ADDR_PROF_P, p);
    apb(1'b1, ADDR_PROF_I, i);
    apb(1'b1, ADDR_PROF_D, d);
    apb(1'b1, ADDR_PROF_ACC, acc);
    apb(1'b1, ADDR_PROF_CMD, 32'h0000_0001);
  endtask : prof

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] regs [4] = '{ADDR_VEL_FF, ADDR_ACCEL_FF, ADDR_DECEL, ADDR_MODE_SEL};
    foreach (regs[k]) begin
      apb(1'b0, regs[k], 32'h0);
      chk("reg_reset", 32'h0, rd);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_reset", 32'h0000_0001, rd);
    chk("active_reset", 32'h0000_0000, {31'h0, cmd_out.active});
    chk("sat_reset", 32'h0000_0000, {31'h0, cmd_out.sat});
    apb(1'b1, 32'h0000_0100, 32'h1234_5678);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
  endtask : t_reset

  task automatic t_pid();
    set_pos(32'sd0, 32'sd10);
    prof(32'd2, 32'd1, 32'd3, 32'd100);
    wait_code(16'd50);
    wait_code(16'd30);
    wait_code(16'd40);
  endtask : t_pid

  task automatic t_sat();
    set_pos(32'sd0, 32'sd1000000);
    wait_code(16'h7FFF);
    chk("cmd_sat", 32'h0000_0001, {31'h0, cmd_out.sat});
    chk("cmd_active", 32'h0000_0001, {31'h0, cmd_out.active});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_sat", 32'h7FFF_0031, rd);
    set_pos(32'sd0, -32'sd1000000);
    wait_code(16'h8001);
    set_pos(32'sd0, 32'sd0);
    apb(1'b1, ADDR_PROF_CMD, 32'h0000_0002);
    wait_code(16'h0000);
    chk("cmd_sat_clear", 32'h0000_0000, {31'h0, cmd_out.sat});
  endtask : t_sat

  task automatic t_ff();
    apb(1'b1, ADDR_MODE_SEL, FSEL_FF);
    apb(1'b1, ADDR_ACCEL_FF, 32'd2);
    apb(1'b1, ADDR_VEL_FF, 32'd3);
    prof(32'd2, 32'd255, 32'd255, 32'd100);
    wait_code(16'h0000);
    set_pos(32'sd4, 32'sd0);
    wait_code(16'd20);
    wait_code(16'hFFF8);
    set_pos(32'sd4, 32'sd5);
    wait_code(16'd10);
    repeat (3 * DIV) @(posedge pclk);
    chk("ff_hold", 32'd10, {16'h0000, cmd_out.code});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_ff", 32'h0000_0012, {16'h0000, rd[15:0]});
  endtask : t_ff

  task automatic t_direct();
    apb(1'b1, ADDR_MODE_SEL, FSEL_DIR_POS);
    apb(1'b1, ADDR_VEL_FF, 32'd1234);
    apb(1'b0, ADDR_VEL_FF, 32'h0);
    chk("vel_ff_rw", 32'd1234, rd);
    repeat (3 * DIV) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("no_direct_yet", 32'h0000_0012, {16'h0000, rd[15:0]});
    prof(32'd1, 32'd0, 32'd0, 32'd100);
    wait_code(16'd1234);
    apb(1'b1, ADDR_MODE_SEL, FSEL_DIR_NEG);
    prof(32'd1, 32'd0, 32'd0, 32'd100);
    wait_code(16'hFB2E);
    apb(1'b1, ADDR_VEL_FF, 32'd40000);
    wait_code(16'h8001);
  endtask : t_direct

  task automatic t_decel();
    apb(1'b1, ADDR_MODE_SEL, 32'h0000_0003);
    prof(32'd1, 32'd0, 32'd0, 32'd100000);
    apb(1'b0, ADDR_DECEL, 32'h0);
    chk("decel_from_accel", 32'd100000, rd);
    apb(1'b1, ADDR_DECEL, 32'd20000);
    apb(1'b0, ADDR_DECEL, 32'h0);
    chk("decel_override", 32'd20000, rd);
    apb(1'b0, ADDR_ACC_RATE, 32'h0);
    chk("accel_kept", 32'd100000, rd);
    prof(32'd1, 32'd0, 32'd0, 32'd300000);
    apb(1'b0, ADDR_DECEL, 32'h0);
    chk("decel_renewed", 32'd300000, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_pid", 32'h0000_0011, {16'h0000, rd[15:0]});
  endtask : t_decel

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pid();
    t_sat();
    t_ff();
    t_direct();
    t_decel();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
